/* rtl/imu_tick_sync.sv */
// Tick counter, sample timing and sensor power coordination
`timescale 1ns/1ps
`default_nettype none

module imu_tick_sync (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Neighbouring logic
    input wire logic [2:0] fifo_downs_i,
    input wire logic fifo_read_done_i,
    input wire logic any_motion_i,
    input wire logic no_motion_i,
    // Timing outputs
    output logic [23:0] tick_counter_o,
    output logic sample_strobe_o,
    output logic data_update_o,
    output logic fifo_update_o,
    output logic new_sample_line_o,
    output logic [23:0] fifo_stamp_o,
    // Power outputs
    output logic [2:0] accel_mode_o,
    output logic [2:0] gyro_mode_o,
    output logic accel_active_o,
    output logic [7:0] averaging_count_o,
    output logic aux_suspended_o
);

    imu_tick_pkg::state_s st_reg;
    imu_tick_pkg::state_s st_next;

    // Decoded configuration, shared with the checks
    logic [3:0] odr;
    logic [2:0] avg_code;
    logic odr_ok;
    logic [4:0] data_bit;
    logic [5:0] fifo_bit;
    logic cycle_ok;
    logic us_on;

    always_comb begin
        odr = st_reg.accel_config[imu_tick_pkg::ACC_ODR_LSB +: 4];
        avg_code = st_reg.accel_config[imu_tick_pkg::ACC_AVG_LSB +: 3];
        odr_ok = (odr >= imu_tick_pkg::ODR_MIN) && (odr <= imu_tick_pkg::ODR_MAX);
        data_bit = imu_tick_pkg::ODR_TOP_BIT - {1'b0, odr};
        fifo_bit = {1'b0, data_bit} + {3'b000, fifo_downs_i};
        us_on = st_reg.accel_config[imu_tick_pkg::ACCEL_UNDERSAMPLE_ENABLE_BIT];
        // Enough idle time for a suspend phase between samples
        cycle_ok = (odr <= imu_tick_pkg::LP_ODR_MAX)
            && (({1'b0, odr} + {2'b00, avg_code}) <= imu_tick_pkg::LP_SUM_MAX);
    end

    always_comb begin
        logic [23:0] inc;
        logic [23:0] flip;
        logic tick;
        logic data_evt;
        logic fifo_evt;
        logic smp_evt;
        logic wr;
        inc = 24'h00_0000;
        flip = 24'h00_0000;
        tick = 1'b0;
        data_evt = 1'b0;
        fifo_evt = 1'b0;
        smp_evt = 1'b0;
        wr = 1'b0;
        st_next = st_reg;

        // Free running timebase, no mode gates it
        tick = (st_reg.pre == imu_tick_pkg::PRE_LAST);
        st_next.pre = tick ? 10'h000 : st_reg.pre + 10'h001;
        inc = st_reg.tick + 24'h00_0001;
        flip = inc ^ st_reg.tick;
        if (tick) begin
            st_next.tick = inc;
        end

        // Events fire only on the increment that toggles their bit
        smp_evt = tick && flip[imu_tick_pkg::SAMPLE_BIT];
        data_evt = tick && odr_ok && flip[data_bit];
        fifo_evt = tick && odr_ok && (fifo_bit <= imu_tick_pkg::TOP_BIT)
            && flip[fifo_bit[4:0]];
        st_next.tick_q = tick;
        st_next.sample = smp_evt && (st_reg.acc != imu_tick_pkg::ACC_SUSPEND);
        st_next.data_upd = data_evt && (st_reg.acc != imu_tick_pkg::ACC_SUSPEND);
        st_next.fifo_upd = fifo_evt && (st_reg.acc != imu_tick_pkg::ACC_SUSPEND);
        st_next.new_sample_line = data_evt && (st_reg.acc != imu_tick_pkg::ACC_SUSPEND);

        // Averaging is a power of two, only applied when undersampling
        if (us_on) begin
            st_next.averaging_count = 8'h01 << avg_code;
        end else begin
            st_next.averaging_count = 8'h01;
        end

        // Acquisition phase of the low power cycle
        unique case (st_reg.acc)
            imu_tick_pkg::ACC_SUSPEND: begin
                st_next.active = 1'b0;
                st_next.left = 8'h00;
            end
            imu_tick_pkg::ACC_NORMAL: begin
                st_next.active = 1'b1;
                st_next.left = 8'h00;
            end
            imu_tick_pkg::ACC_LOWPWR: begin
                if (!cycle_ok) begin
                    st_next.active = 1'b1;
                    st_next.left = 8'h00;
                end else if (data_evt) begin
                    st_next.active = 1'b1;
                    st_next.left = st_reg.averaging_count;
                end else if (st_reg.active && smp_evt) begin
                    // Phase ends after the averaged samples are taken
                    if (st_reg.left <= 8'h01) begin
                        st_next.active = 1'b0;
                        st_next.left = 8'h00;
                    end else begin
                        st_next.left = st_reg.left - 8'h01;
                    end
                end
            end
        endcase

        // Gyro auto sleep from the motion detectors
        if (st_reg.auto_cfg[imu_tick_pkg::AUTO_EN_BIT]) begin
            if (st_reg.gyr == imu_tick_pkg::GYR_NORMAL && no_motion_i) begin
                st_next.gyr = st_reg.auto_cfg[imu_tick_pkg::AUTO_FSU_BIT]
                    ? imu_tick_pkg::GYR_FASTUP : imu_tick_pkg::GYR_SUSPEND;
            end else if (st_reg.gyr != imu_tick_pkg::GYR_NORMAL && any_motion_i) begin
                st_next.gyr = imu_tick_pkg::GYR_NORMAL;
            end
        end

        // Timestamp caught after a full FIFO readout
        if (fifo_read_done_i) begin
            st_next.stamp = st_reg.tick;
        end

        // Register writes
        wr = reg_wr_i;
        if (wr) begin
            if (reg_addr_i == imu_tick_pkg::ADDR_ACCEL_CONFIG) begin
                st_next.accel_config = reg_wdata_i;
            end
            if (reg_addr_i >= imu_tick_pkg::ADDR_AUX_FIRST
                && reg_addr_i <= imu_tick_pkg::ADDR_AUX_LAST) begin
                st_next.aux[8 * (reg_addr_i - imu_tick_pkg::ADDR_AUX_FIRST) +: 8] =
                    reg_wdata_i;
            end
            if (reg_addr_i == imu_tick_pkg::ADDR_AUTO_SLEEP) begin
                st_next.auto_cfg = reg_wdata_i;
            end
            // One command moves one sensor only; unknown codes are ignored
            if (reg_addr_i == imu_tick_pkg::ADDR_CMD) begin
                unique case (reg_wdata_i)
                    imu_tick_pkg::CMD_ACC_SUSPEND: begin
                        st_next.acc = imu_tick_pkg::ACC_SUSPEND;
                    end
                    imu_tick_pkg::CMD_ACC_NORMAL: st_next.acc = imu_tick_pkg::ACC_NORMAL;
                    imu_tick_pkg::CMD_ACC_LOWPWR: st_next.acc = imu_tick_pkg::ACC_LOWPWR;
                    imu_tick_pkg::CMD_GYR_SUSPEND: st_next.gyr = imu_tick_pkg::GYR_SUSPEND;
                    imu_tick_pkg::CMD_GYR_NORMAL: st_next.gyr = imu_tick_pkg::GYR_NORMAL;
                    imu_tick_pkg::CMD_GYR_FASTUP: st_next.gyr = imu_tick_pkg::GYR_FASTUP;
                    // Only the interface state moves; the magnetometer gets no message
                    imu_tick_pkg::CMD_AUX_SUSPEND: st_next.aux_susp = 1'b1;
                    imu_tick_pkg::CMD_AUX_NORMAL: st_next.aux_susp = 1'b0;
                    default: begin
                    end
                endcase
            end
        end

        // Register reads, answered one cycle later
        if (reg_rd_i) begin
            st_next.rdata = 8'h00;
            case (reg_addr_i)
                imu_tick_pkg::ADDR_TICK0: begin
                    // Low byte read freezes the upper bytes for a coherent value
                    st_next.rdata = st_reg.tick[7:0];
                    st_next.shadow = st_reg.tick;
                end
                imu_tick_pkg::ADDR_TICK1: st_next.rdata = st_reg.shadow[15:8];
                imu_tick_pkg::ADDR_TICK2: st_next.rdata = st_reg.shadow[23:16];
                imu_tick_pkg::ADDR_ACCEL_CONFIG: st_next.rdata = st_reg.accel_config;
                imu_tick_pkg::ADDR_AUTO_SLEEP: st_next.rdata = st_reg.auto_cfg;
                default: begin
                    if (reg_addr_i >= imu_tick_pkg::ADDR_AUX_FIRST
                        && reg_addr_i <= imu_tick_pkg::ADDR_AUX_LAST) begin
                        st_next.rdata =
                            st_reg.aux[8 * (reg_addr_i - imu_tick_pkg::ADDR_AUX_FIRST) +: 8];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_reg <= '{
                pre: 10'h000,
                tick: 24'h00_0000,
                shadow: 24'h00_0000,
                accel_config: imu_tick_pkg::ACCEL_CONFIG_RST,
                aux: imu_tick_pkg::AUX_CONF_RST,
                auto_cfg: imu_tick_pkg::AUTO_SLEEP_RST,
                acc: imu_tick_pkg::ACC_SUSPEND,
                gyr: imu_tick_pkg::GYR_SUSPEND,
                aux_susp: 1'b0,
                active: 1'b0,
                left: 8'h00,
                rdata: 8'h00,
                tick_q: 1'b0,
                data_upd: 1'b0,
                fifo_upd: 1'b0,
                sample: 1'b0,
                new_sample_line: 1'b0,
                stamp: 24'h00_0000,
                averaging_count: 8'h01
            };
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_o = st_reg.rdata;
    assign tick_counter_o = st_reg.tick;
    assign sample_strobe_o = st_reg.sample;
    assign data_update_o = st_reg.data_upd;
    assign fifo_update_o = st_reg.fifo_upd;
    assign new_sample_line_o = st_reg.new_sample_line;
    assign fifo_stamp_o = st_reg.stamp;
    assign accel_mode_o = st_reg.acc;
    assign gyro_mode_o = st_reg.gyr;
    assign accel_active_o = st_reg.active;
    assign averaging_count_o = st_reg.averaging_count;
    assign aux_suspended_o = st_reg.aux_susp;

    chk_tick_period: assert property (@(posedge mclk_i) disable iff (reset_i)
        st_reg.tick_q |-> ##[780:780] st_reg.tick_q)
        else $error("tick spacing is not 780 cycles");

    chk_tick_gap: assert property (@(posedge mclk_i) disable iff (reset_i)
        st_reg.tick_q |=> !st_reg.tick_q [*8])
        else $error("tick came too early");

    chk_counter_step: assert property (@(posedge mclk_i) disable iff (reset_i)
        st_reg.tick_q |-> tick_counter_o == 24'($past(tick_counter_o) + 24'h00_0001))
        else $error("counter did not step by one");

    chk_counter_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
        !st_reg.tick_q |-> $stable(tick_counter_o))
        else $error("counter moved without a tick");

    chk_update_bit: assert property (@(posedge mclk_i) disable iff (reset_i)
        data_update_o && $stable(st_reg.accel_config)
        |-> tick_counter_o[data_bit] != $past(tick_counter_o[data_bit]))
        else $error("update without its counter bit toggling");

    chk_sample_align: assert property (@(posedge mclk_i) disable iff (reset_i)
        sample_strobe_o |-> st_reg.tick_q && tick_counter_o[3:0] == 4'h0)
        else $error("sample strobe off the 1600 Hz boundary");

    chk_new_sample_line_common: assert property (@(posedge mclk_i) disable iff (reset_i)
        new_sample_line_o |-> data_update_o && st_reg.tick_q)
        else $error("new sample line without a data update");

    chk_lp_active: assert property (@(posedge mclk_i) disable iff (reset_i)
        accel_mode_o == imu_tick_pkg::ACC_LOWPWR && !$past(cycle_ok)
        && $past(accel_mode_o) == imu_tick_pkg::ACC_LOWPWR |-> accel_active_o)
        else $error("low power cycled with no room to sleep");

    chk_gyro_sleep: assert property (@(posedge mclk_i) disable iff (reset_i)
        st_reg.auto_cfg[imu_tick_pkg::AUTO_EN_BIT] && no_motion_i && !reg_wr_i
        && gyro_mode_o == imu_tick_pkg::GYR_NORMAL
        |=> gyro_mode_o != imu_tick_pkg::GYR_NORMAL)
        else $error("gyro stayed awake on no motion");

    chk_fifo_stamp: assert property (@(posedge mclk_i) disable iff (reset_i)
        fifo_read_done_i |=> fifo_stamp_o == $past(tick_counter_o))
        else $error("fifo timestamp not captured");

    chk_aux_cmd: assert property (@(posedge mclk_i) disable iff (reset_i)
        $changed(aux_suspended_o) |-> $past(reg_wr_i && reg_addr_i == imu_tick_pkg::ADDR_CMD))
        else $error("aux state changed without a command");

    chk_fifo_bit: assert property (@(posedge mclk_i) disable iff (reset_i)
        fifo_update_o && $stable(st_reg.accel_config) && $stable(fifo_downs_i)
        |-> tick_counter_o[fifo_bit[4:0]] != $past(tick_counter_o[fifo_bit[4:0]]))
        else $error("fifo update without its counter bit toggling");

    chk_sample_gated: assert property (@(posedge mclk_i) disable iff (reset_i)
        sample_strobe_o |-> $past(accel_mode_o) != imu_tick_pkg::ACC_SUSPEND)
        else $error("sample strobe while the accelerometer slept");

    chk_update_gated: assert property (@(posedge mclk_i) disable iff (reset_i)
        data_update_o |-> $past(odr_ok) && $past(accel_mode_o) != imu_tick_pkg::ACC_SUSPEND)
        else $error("data update with a bad rate or in suspend");

    chk_avg_power: assert property (@(posedge mclk_i) disable iff (reset_i)
        $onehot(averaging_count_o))
        else $error("averaging count is not a power of two");

    chk_avg_plain: assert property (@(posedge mclk_i) disable iff (reset_i)
        !$past(us_on) |-> averaging_count_o == 8'h01)
        else $error("averaging applied without undersampling");

    chk_active_fall: assert property (@(posedge mclk_i) disable iff (reset_i)
        $fell(accel_active_o) |-> $past(accel_mode_o) != imu_tick_pkg::ACC_NORMAL)
        else $error("acquisition ended in normal mode");

    chk_active_rise: assert property (@(posedge mclk_i) disable iff (reset_i)
        $rose(accel_active_o) && $past(accel_mode_o) == imu_tick_pkg::ACC_LOWPWR
        && $past(cycle_ok) |-> data_update_o)
        else $error("acquisition started off an output update");

    chk_gyro_wake: assert property (@(posedge mclk_i) disable iff (reset_i)
        st_reg.auto_cfg[imu_tick_pkg::AUTO_EN_BIT] && any_motion_i && !reg_wr_i
        && gyro_mode_o != imu_tick_pkg::GYR_NORMAL
        |=> gyro_mode_o == imu_tick_pkg::GYR_NORMAL)
        else $error("gyro stayed asleep on motion");

endmodule

`default_nettype wire

/* common/imu_tick_pkg.sv */
// Shared constants, modes and state layout for the tick counter and power sync block
package imu_tick_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_TICK0 = 8'h18;
    localparam logic [7:0] ADDR_TICK1 = 8'h19;
    localparam logic [7:0] ADDR_TICK2 = 8'h1a;
    localparam logic [7:0] ADDR_ACCEL_CONFIG = 8'h40;
    localparam logic [7:0] ADDR_AUX_FIRST = 8'h4b;
    localparam logic [7:0] ADDR_AUX_LAST = 8'h4f;
    localparam logic [7:0] ADDR_AUTO_SLEEP = 8'h6c;
    localparam logic [7:0] ADDR_CMD = 8'h7e;

    // Field positions
    localparam int ACC_ODR_LSB = 0;
    localparam int ACC_AVG_LSB = 4;
    localparam int ACCEL_UNDERSAMPLE_ENABLE_BIT = 7;
    localparam int AUTO_EN_BIT = 0;
    localparam int AUTO_FSU_BIT = 1;

    // Reset values
    localparam logic [7:0] ACCEL_CONFIG_RST = 8'h28;
    localparam logic [7:0] AUTO_SLEEP_RST = 8'h00;
    localparam logic [39:0] AUX_CONF_RST = 40'h00_0000_0000;

    // Command codes
    localparam logic [7:0] CMD_ACC_SUSPEND = 8'h20;
    localparam logic [7:0] CMD_ACC_NORMAL = 8'h21;
    localparam logic [7:0] CMD_ACC_LOWPWR = 8'h22;
    localparam logic [7:0] CMD_GYR_SUSPEND = 8'h24;
    localparam logic [7:0] CMD_GYR_NORMAL = 8'h25;
    localparam logic [7:0] CMD_GYR_FASTUP = 8'h26;
    localparam logic [7:0] CMD_AUX_SUSPEND = 8'h28;
    localparam logic [7:0] CMD_AUX_NORMAL = 8'h29;

    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_PERIOD_NS = 39000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [9:0] PRE_LAST = 10'(TICK_CYCLES - 1);

    // Rate to bit mapping
    localparam logic [4:0] ODR_TOP_BIT = 5'h10;
    localparam logic [3:0] ODR_MIN = 4'h1;
    localparam logic [3:0] ODR_MAX = 4'hc;
    localparam logic [3:0] LP_ODR_MAX = 4'ha;
    localparam logic [4:0] LP_SUM_MAX = 5'h0b;
    localparam int SAMPLE_BIT = 4;
    localparam logic [5:0] TOP_BIT = 6'h17;

    typedef enum logic [2:0] {
        ACC_SUSPEND = 3'b001,
        ACC_NORMAL = 3'b010,
        ACC_LOWPWR = 3'b100
    } acc_mode_e;

    typedef enum logic [2:0] {
        GYR_SUSPEND = 3'b001,
        GYR_FASTUP = 3'b010,
        GYR_NORMAL = 3'b100
    } gyr_mode_e;

    typedef struct packed {
        logic [9:0] pre;
        logic [23:0] tick;
        logic [23:0] shadow;
        logic [7:0] accel_config;
        logic [39:0] aux;
        logic [7:0] auto_cfg;
        acc_mode_e acc;
        gyr_mode_e gyr;
        logic aux_susp;
        logic active;
        logic [7:0] left;
        logic [7:0] rdata;
        logic tick_q;
        logic data_upd;
        logic fifo_upd;
        logic sample;
        logic new_sample_line;
        logic [23:0] stamp;
        logic [7:0] averaging_count;
    } state_s;

endpackage

/* dv/host_model.sv */
// Host model driving the register port of the tick block
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input wire logic mclk_i,
    // Register port
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end
    // Request held from a falling edge across the taking edge
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge mclk_i);
        reg_addr_o = addr;
        reg_wdata_o = data;
        reg_wr_o = 1'b1;
        @(negedge mclk_i);
        reg_wr_o = 1'b0;
        reg_addr_o = ~addr;
        reg_wdata_o = ~data;
    endtask
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge mclk_i);
        reg_addr_o = addr;
        reg_rd_o = 1'b1;
        @(negedge mclk_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~addr;
        data = reg_rdata_i;
    endtask
    // One sensor per command; magnetometer parked by hand before its interface sleeps
    task automatic set_mode(input logic [7:0] code);
        if (code == imu_tick_pkg::CMD_AUX_SUSPEND) begin
            wr(imu_tick_pkg::ADDR_AUX_FIRST, 8'h80);
        end
        wr(imu_tick_pkg::ADDR_CMD, code);
    endtask
endmodule
`default_nettype wire

/* dv/test_imu_tick_sync.sv */
// Self-checking bench for the tick counter and power sync block
`timescale 1ns/1ps
`default_nettype none
module test_imu_tick_sync;
    logic mclk_i, reset_i, reg_wr_i, reg_rd_i, fifo_read_done_i, any_motion_i, no_motion_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, averaging_count_o;
    logic [2:0] fifo_downs_i, accel_mode_o, gyro_mode_o;
    logic [23:0] tick_counter_o, fifo_stamp_o, prev, chg;
    logic sample_strobe_o, data_update_o, fifo_update_o, new_sample_line_o;
    logic accel_active_o, aux_suspended_o, mon_on, acc_on, have, exp_d, exp_f;
    logic [3:0] odr;
    int bad_count, compares, cyc, fi;
    int dcount = 0;
    int fcount = 0;
    host_model i_host_model (
        .mclk_i(mclk_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o)
    );
    imu_tick_sync i_imu_tick_sync (
        .mclk_i(mclk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .fifo_downs_i(fifo_downs_i),
        .fifo_read_done_i(fifo_read_done_i), .any_motion_i(any_motion_i),
        .no_motion_i(no_motion_i), .tick_counter_o(tick_counter_o),
        .sample_strobe_o(sample_strobe_o), .data_update_o(data_update_o),
        .fifo_update_o(fifo_update_o), .new_sample_line_o(new_sample_line_o),
        .fifo_stamp_o(fifo_stamp_o), .accel_mode_o(accel_mode_o), .gyro_mode_o(gyro_mode_o),
        .accel_active_o(accel_active_o), .averaging_count_o(averaging_count_o),
        .aux_suspended_o(aux_suspended_o)
    );
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    task automatic check_val(input logic [23:0] got, input logic [23:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic timeout();
        bad_count++;
        $display("[FAIL] %0t wait ran out", $time);
        stop_test();
    endtask
    // Expected pulses follow from which counter bits flipped
    always @(negedge mclk_i) begin
        chg = tick_counter_o ^ prev;
        fi = 16 - int'(odr) + int'(fifo_downs_i);
        exp_d = acc_on & chg[16 - int'(odr)];
        exp_f = acc_on & (fi <= 23) & chg[fi];
        if (reset_i) begin
            cyc = 0;
            have = 1'b0;
        end else if (mon_on) begin
            check_val(24'(data_update_o), 24'(exp_d), "data update");
            check_val(24'(new_sample_line_o), 24'(exp_d), "new sample");
            check_val(24'(fifo_update_o), 24'(exp_f), "fifo update");
            check_val(24'(sample_strobe_o), 24'(acc_on & chg[4]), "sample strobe");
        end
        cyc = cyc + 1;
        if (!reset_i && chg != 24'h0) begin
            if (mon_on && have) begin
                check_val(24'(cyc), 24'h30c, "tick period");
                check_val(tick_counter_o, prev + 24'h1, "tick step");
            end
            have = 1'b1;
            cyc = 0;
        end
        dcount = dcount + int'(data_update_o === 1'b1);
        fcount = fcount + int'(fifo_update_o === 1'b1);
        prev = tick_counter_o;
    end
    task automatic t_reset();
        logic [7:0] a [9] = '{8'h40, 8'h6c, 8'h4b, 8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h7e, 8'h30};
        logic [7:0] d;
        check_val(24'(accel_mode_o), 24'h1, "accel mode");
        check_val(24'(gyro_mode_o), 24'h1, "gyro mode");
        check_val(24'(averaging_count_o), 24'h1, "averaging");
        for (int i = 0; i < 9; i++) begin
            i_host_model.rd(a[i], d);
            check_val(24'(d), (i == 0) ? 24'h28 : 24'h0, "reset value");
        end
        i_host_model.wr(8'h6c, 8'h02);
        i_host_model.wr(8'h4f, 8'h5a);
        i_host_model.rd(8'h6c, d);
        check_val(24'(d), 24'h2, "auto sleep rw");
        i_host_model.rd(8'h4f, d);
        check_val(24'(d), 24'h5a, "aux rw");
        i_host_model.wr(8'h6c, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_commands();
        logic [7:0] c [9] = '{8'h21, 8'h25, 8'h28, 8'h23, 8'h26, 8'h22, 8'h29, 8'h24, 8'h20};
        logic [2:0] ea [9] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h4, 3'h4, 3'h4, 3'h1};
        logic [2:0] eg [9] = '{3'h1, 3'h4, 3'h4, 3'h4, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1};
        logic [8:0] ex = 9'h03c;
        logic [7:0] d;
        for (int i = 0; i < 9; i++) begin
            i_host_model.set_mode(c[i]);
            repeat (2) @(negedge mclk_i);
            check_val(24'(accel_mode_o), 24'(ea[i]), "accel mode");
            check_val(24'(gyro_mode_o), 24'(eg[i]), "gyro mode");
            check_val(24'(aux_suspended_o), 24'(ex[i]), "aux suspend");
        end
        i_host_model.rd(8'h4b, d);
        check_val(24'(d), 24'h80, "aux config kept");
        $display("test commands done");
    endtask
    task automatic t_avg();
        for (int k = 0; k < 8; k++) begin
            i_host_model.wr(8'h40, {1'b1, 3'(k), 4'h8});
            repeat (2) @(negedge mclk_i);
            check_val(24'(averaging_count_o), 24'h1 << k, "averaging");
        end
        i_host_model.wr(8'h40, 8'h7b);
        repeat (2) @(negedge mclk_i);
        check_val(24'(averaging_count_o), 24'h1, "no undersample");
        i_host_model.wr(8'h40, 8'hfb);
        i_host_model.set_mode(8'h22);
        repeat (4) @(negedge mclk_i);
        check_val(24'(accel_active_o), 24'h1, "no room to sleep");
        i_host_model.set_mode(8'h20);
        // Room to sleep: no acquisition until the next output update
        i_host_model.wr(8'h40, 8'h8a);
        i_host_model.set_mode(8'h22);
        repeat (4) @(negedge mclk_i);
        check_val(24'(accel_active_o), 24'h0, "sleep between samples");
        i_host_model.set_mode(8'h20);
        $display("test averaging done");
    endtask
    task automatic motion(input logic mv, input logic still, input logic [2:0] e, input string w);
        any_motion_i = mv;
        no_motion_i = still;
        repeat (3) @(negedge mclk_i);
        check_val(24'(gyro_mode_o), 24'(e), w);
        any_motion_i = 1'b0;
        no_motion_i = 1'b0;
    endtask
    task automatic t_auto();
        i_host_model.wr(8'h6c, 8'h01);
        i_host_model.set_mode(8'h25);
        motion(1'b0, 1'b1, 3'h1, "auto suspend");
        motion(1'b1, 1'b0, 3'h4, "auto wake");
        i_host_model.wr(8'h6c, 8'h03);
        motion(1'b0, 1'b1, 3'h2, "auto fast start");
        motion(1'b1, 1'b0, 3'h4, "auto wake");
        i_host_model.wr(8'h6c, 8'h00);
        motion(1'b0, 1'b1, 3'h4, "auto off");
        i_host_model.set_mode(8'h24);
        $display("test auto sleep done");
    endtask
    // Long enough for bit 4 to flip at least once while suspended
    task automatic t_suspend();
        acc_on = 1'b0;
        dcount = 0;
        mon_on = 1'b1;
        repeat (13000) @(negedge mclk_i);
        mon_on = 1'b0;
        check_val(24'(dcount), 24'h0, "no update in suspend");
        $display("test suspend done");
    endtask
    task automatic t_stamp();
        logic [23:0] e;
        logic [7:0] b0, b1, b2;
        @(negedge mclk_i);
        fifo_read_done_i = 1'b1;
        e = tick_counter_o;
        @(negedge mclk_i);
        fifo_read_done_i = 1'b0;
        @(negedge mclk_i);
        check_val(fifo_stamp_o, e, "fifo stamp");
        e = tick_counter_o;
        for (int i = 0; i < 800 && tick_counter_o === e; i++) @(negedge mclk_i);
        if (tick_counter_o === e) timeout();
        e = tick_counter_o;
        i_host_model.rd(8'h18, b0);
        i_host_model.rd(8'h19, b1);
        i_host_model.rd(8'h1a, b2);
        check_val({b2, b1, b0}, e, "counter read");
        $display("test stamp done");
    endtask
    task automatic t_normal();
        int n;
        i_host_model.wr(8'h40, 8'h2c);
        i_host_model.set_mode(8'h21);
        repeat (2) @(negedge mclk_i);
        acc_on = 1'b1;
        dcount = 0;
        fcount = 0;
        mon_on = 1'b1;
        for (n = 0; n < 40000 && (dcount < 2 || fcount < 1); n++) @(negedge mclk_i);
        mon_on = 1'b0;
        if (n == 40000) timeout();
        $display("test normal done");
    endtask
    initial begin
        reset_i = 1'b1;
        fifo_downs_i = 3'h1;
        fifo_read_done_i = 1'b0;
        any_motion_i = 1'b0;
        no_motion_i = 1'b0;
        mon_on = 1'b0;
        acc_on = 1'b0;
        odr = 4'hc;
        bad_count = 0;
        compares = 0;
        repeat (10) @(negedge mclk_i);
        reset_i = 1'b0;
        t_reset();
        t_commands();
        t_avg();
        t_auto();
        t_suspend();
        t_stamp();
        t_normal();
        stop_test();
    end
endmodule
`default_nettype wire
